// *** hdl/page_mode_external_bus.sv ***
// Page-mode external memory bus sequencer with registered pin drivers
`timescale 1ns/1ps
`include "page_bus_defines.svh"
module page_mode_external_bus
  import page_bus_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  wire logic [1:0] req_kind,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            req_ready,
  output logic            resp_valid,
  output logic [7:0]      resp_rdata,
  input  wire logic       address_control_reg_write,
  input  wire logic [7:0] address_control_reg_wdata,
  input  wire logic       timed_access_open,
  input  wire logic [2:0] stretch_select,
  output logic [7:0]      address_control_reg,
  output logic            page_miss_seen,
  input  wire logic [7:0] low_port_in,
  output logic [7:0]      low_port_out,
  output logic            low_port_oe,
  input  wire logic [7:0] high_port_in,
  output logic [7:0]      high_port_out,
  output logic            high_port_oe,
  output logic            ale,
  output logic            program_store_strobe_n,
  output logic            rd_n,
  output logic            wr_n
);

  // Phase lengths for one transfer; hit half splits into address lead and strobe
  function automatic plan_s make_plan(input logic pg, input logic [1:0] sel,
                                      input logic data, input logic [2:0] code);
    plan_s p;
    logic [5:0] h;
    p = '0;
    h = `LEN_ZERO;
    if (pg && sel != `SEL_PM2) begin
      h        = `LEN_ONE << sel;
      p.alen   = h;
      p.setup  = h >> 1;
      p.strobe = h - (h >> 1);
    end else if (pg && !data) begin
      p.alen   = `PM2_MISS_LEN;
      p.setup  = `PM2_SETUP_LEN;
      p.strobe = `PM2_STB_LEN;
    end else begin
      p.alen   = `CONV_ADDR_LEN;
      p.setup  = `CONV_SETUP_LEN;
      p.strobe = `CONV_STB_LEN;
    end
    if (data && code != 3'h0) begin
      // Each added stretch cycle is four clocks split over setup, strobe and hold
      p.strobe = p.strobe + `STRETCH_CLKS * {3'h0, code} - `STB_TRIM;
      if (code < `ST_SLOW_MIN) begin
        p.setup = p.setup + `ST_FAST_SETUP;
        p.hold  = `ST_FAST_HOLD;
      end else begin
        p.setup = p.setup + `ST_SLOW_SETUP;
        p.hold  = `ST_SLOW_HOLD;
      end
    end
    return p;
  endfunction

  phase_if ph ();

  phase_timer u_timer (
    .clk (clk),
    .rst (rst),
    .ph  (ph)
  );

  state_e      state_r;
  state_e      state_nxt;
  logic [7:0]  address_control_reg_r;
  logic [7:0]  page_r;
  logic        page_valid_r;
  logic        force_next_r;
  logic        pg_r;
  logic [1:0]  sel_r;
  kind_e       kind_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  plan_s       plan_r;
  plan_s       plan_nxt;
  logic        pg_now;
  logic [1:0]  sel_now;
  logic        data_now;
  logic        miss_now;
  logic        fin_now;
  logic        take;
  logic [5:0]  hold_eff;
  logic        cap_r;
  logic        end_r;
  logic        hi_data_r;
  logic [7:0]  lo_nxt;
  logic        lo_oe_nxt;
  logic [7:0]  hi_nxt;
  logic        hi_oe_nxt;
  logic        ale_nxt;
  logic        stb_nxt;

  assign pg_now   = address_control_reg_r[`ADDRESS_CONTROL_REG_EN_BIT];
  assign sel_now  = address_control_reg_r[`ADDRESS_CONTROL_REG_SEL_HI:`ADDRESS_CONTROL_REG_SEL_LO];
  assign data_now = (req_kind != KIND_FETCH);
  assign plan_nxt = make_plan(pg_now, sel_now, data_now, stretch_select);

  // Miss when page unknown, upper byte moved, or forced around data moves
  always_comb begin
    miss_now = 1'b1;
    if (pg_now && !(sel_now == `SEL_PM2 && data_now)) begin
      miss_now = !page_valid_r || (req_addr[15:8] != page_r);
      if (sel_now == `SEL_1CLK && (data_now || force_next_r)) begin
        miss_now = 1'b1;
      end
    end
  end

  assign fin_now = (state_r == ST_IDLE) || (state_r == ST_HOLD && ph.last)
                || (state_r == ST_STROBE && ph.last && plan_r.hold == `LEN_ZERO);
  assign take     = req_valid && fin_now;
  assign hold_eff = take ? plan_nxt.hold : plan_r.hold;

  // Sequencer: back-to-back takes avoid a gap so select 00 hit fetch strobes stay joined
  always_comb begin
    state_nxt = state_r;
    ph.load   = 1'b0;
    ph.len    = `LEN_ONE;
    if (take) begin
      ph.load = 1'b1;
      if (miss_now) begin
        state_nxt = ST_ADDRHI;
        ph.len    = plan_nxt.alen;
      end else if (plan_nxt.setup != `LEN_ZERO) begin
        state_nxt = ST_SETUP;
        ph.len    = plan_nxt.setup;
      end else begin
        state_nxt = ST_STROBE;
        ph.len    = plan_nxt.strobe;
      end
    end else begin
      case (state_r)
        ST_IDLE:   state_nxt = ST_IDLE;
        ST_ADDRHI: begin
          if (ph.last) begin
            ph.load = 1'b1;
            if (plan_r.setup != `LEN_ZERO) begin
              state_nxt = ST_SETUP;
              ph.len    = plan_r.setup;
            end else begin
              state_nxt = ST_STROBE;
              ph.len    = plan_r.strobe;
            end
          end
        end
        ST_SETUP: begin
          if (ph.last) begin
            ph.load   = 1'b1;
            state_nxt = ST_STROBE;
            ph.len    = plan_r.strobe;
          end
        end
        ST_STROBE: begin
          if (ph.last && plan_r.hold != `LEN_ZERO) begin
            ph.load   = 1'b1;
            state_nxt = ST_HOLD;
            ph.len    = plan_r.hold;
          end else if (ph.last) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (ph.last) begin
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ready predicts next cycle's take point so it can be a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready <= 1'b1;
    end else begin
      req_ready <= (state_nxt == ST_IDLE)
                || (state_nxt == ST_STROBE && ph.last_nxt && hold_eff == `LEN_ZERO)
                || (state_nxt == ST_HOLD && ph.last_nxt);
    end
  end

  // Address control register only moves inside a timed-access window
  always_ff @(posedge clk) begin
    if (rst) begin
      address_control_reg_r <= `ADDRESS_CONTROL_REG_RESET;
    end else if (address_control_reg_write && timed_access_open) begin
      address_control_reg_r <= address_control_reg_wdata;
    end
  end

  assign address_control_reg = address_control_reg_r;

  // Page tracking; any mode change or page mode off forgets the page
  always_ff @(posedge clk) begin
    if (rst) begin
      page_r         <= 8'h00;
      page_valid_r   <= 1'b0;
      force_next_r   <= 1'b0;
      page_miss_seen <= 1'b0;
    end else if ((address_control_reg_write && timed_access_open) || !pg_now) begin
      page_valid_r <= 1'b0;
      force_next_r <= 1'b0;
    end else if (take) begin
      page_r         <= req_addr[15:8];
      page_valid_r   <= 1'b1;
      force_next_r   <= data_now && sel_now == `SEL_1CLK;
      page_miss_seen <= miss_now;
    end
  end

  // Transfer context captured at take
  always_ff @(posedge clk) begin
    if (rst) begin
      pg_r    <= 1'b0;
      sel_r   <= `SEL_1CLK;
      kind_r  <= KIND_FETCH;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
      plan_r  <= '0;
    end else if (take) begin
      pg_r    <= pg_now;
      sel_r   <= sel_now;
      kind_r  <= kind_e'(req_kind);
      addr_r  <= req_addr;
      wdata_r <= req_wdata;
      plan_r  <= plan_nxt;
    end
  end

  // Pin values for the current phase; registered below so pins lag one clock
  always_comb begin
    lo_nxt    = 8'h00;
    lo_oe_nxt = 1'b0;
    hi_nxt    = 8'h00;
    hi_oe_nxt = 1'b0;
    ale_nxt   = 1'b0;
    stb_nxt   = (state_r == ST_STROBE);
    if (state_r == ST_ADDRHI) begin
      ale_nxt   = !ph.last || (plan_r.alen == `LEN_ONE);
      hi_nxt    = addr_r[15:8];
      hi_oe_nxt = 1'b1;
      if (!pg_r || sel_r == `SEL_PM2) begin
        lo_nxt    = addr_r[7:0];
        lo_oe_nxt = 1'b1;
      end
    end else if (state_r != ST_IDLE) begin
      if (pg_r && sel_r != `SEL_PM2) begin
        hi_nxt    = addr_r[7:0];
        hi_oe_nxt = 1'b1;
        lo_nxt    = wdata_r;
        lo_oe_nxt = (kind_r == KIND_WRITE);
      end else if (pg_r) begin
        lo_nxt    = addr_r[7:0];
        lo_oe_nxt = 1'b1;
        hi_nxt    = wdata_r;
        hi_oe_nxt = (kind_r == KIND_WRITE);
      end else begin
        hi_nxt    = addr_r[15:8];
        hi_oe_nxt = 1'b1;
        lo_nxt    = wdata_r;
        lo_oe_nxt = (kind_r == KIND_WRITE);
      end
    end
  end

  // ALE falls a clock before the byte moves; one-clock phases keep it throughout
  always_ff @(posedge clk) begin
    if (rst) begin
      ale <= 1'b0;
    end else begin
      ale <= ale_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_port_out           <= 8'h00;
      low_port_oe            <= 1'b0;
      high_port_out          <= 8'h00;
      high_port_oe           <= 1'b0;
      program_store_strobe_n <= 1'b1;
      rd_n                   <= 1'b1;
      wr_n                   <= 1'b1;
    end else begin
      low_port_out           <= lo_nxt;
      low_port_oe            <= lo_oe_nxt;
      high_port_out          <= hi_nxt;
      high_port_oe           <= hi_oe_nxt;
      program_store_strobe_n <= !(stb_nxt && kind_r == KIND_FETCH);
      rd_n                   <= !(stb_nxt && kind_r == KIND_READ);
      wr_n                   <= !(stb_nxt && kind_r == KIND_WRITE);
    end
  end

  // Read data sampled in the last strobe clock, i.e. at the strobe's rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_r      <= 1'b0;
      end_r      <= 1'b0;
      hi_data_r  <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 8'h00;
    end else begin
      cap_r      <= state_r == ST_STROBE && ph.last && kind_r != KIND_WRITE;
      end_r      <= fin_now && state_r != ST_IDLE;
      hi_data_r  <= pg_r && sel_r == `SEL_PM2;
      resp_valid <= end_r;
      if (cap_r) begin
        resp_rdata <= hi_data_r ? high_port_in : low_port_in;
      end
    end
  end

endmodule

// *** inc/page_bus_defines.svh ***
// Constants of the page-mode external bus: bit positions, reset values, phase lengths
// Behaviour
// - Page mode enable set selects page cycles; cleared selects conventional multiplexed bus.
// - Address control register writes take effect only inside a timed-access window.
// - Select 00/01/10 give hits of 1/2/4 and misses of 2/4/8 clocks.
// - Page mode 1 puts both address bytes on high port; low port carries data.
// - Select 11: low address on low port, high port muxes address/data; fetch 2/4.
// - Page mode 2 data cycles take four clocks, hit or miss alike.
// - Page mode 1 fetch floats low port; opcode latched at strobe rising edge.
// - Data reads float the data port; data writes drive write data on it.
// - Changed upper address byte versus previous access is a miss, else a hit.
// - Hit drives low address byte on high port and strobes without address latch.
// - Miss first half drives upper byte, pulses latch strobe, strobes idle, low floats.
// - Upper byte stored per access; first access after entering page mode misses.
// - Select 00 holds fetch strobe a full clock, continuous across hit fetches.
// - Select 00 forces miss on every data move and on the following fetch.
// - Select 01 holds fetch strobe active one full clock per fetch.
// - Each stretch cycle added to a page-mode data access is four clocks.
// - Stretch codes 000-011 add 0-3 cycles; 100-111 add 7-10 cycles.
// - Select 00 strobe widths 1,3,7,11,15,19,23,27 clocks for codes 000-111.
// - Three-bit stretch select may be rewritten by software at any time.
// - Select 00 stretch widths follow the one-clock page mode 1 table.
// - Stretch 1 adds one setup clock and one hold clock, not four strobe clocks.
`ifndef PAGE_BUS_DEFINES_SVH
`define PAGE_BUS_DEFINES_SVH

`define LEN_W          6
`define ADDRESS_CONTROL_REG_RESET     8'h00
`define ADDRESS_CONTROL_REG_EN_BIT    7
`define ADDRESS_CONTROL_REG_SEL_HI    6
`define ADDRESS_CONTROL_REG_SEL_LO    5
`define SEL_1CLK       2'h0
`define SEL_2CLK       2'h1
`define SEL_4CLK       2'h2
`define SEL_PM2        2'h3
`define CONV_ADDR_LEN  6'h01
`define CONV_SETUP_LEN 6'h01
`define CONV_STB_LEN   6'h02
`define PM2_MISS_LEN   6'h02
`define PM2_SETUP_LEN  6'h01
`define PM2_STB_LEN    6'h01
`define STRETCH_CLKS   6'h04
`define STB_TRIM       6'h02
`define ST_FAST_SETUP  6'h01
`define ST_FAST_HOLD   6'h01
`define ST_SLOW_SETUP  6'h08
`define ST_SLOW_HOLD   6'h06
`define ST_SLOW_MIN    3'h4
`define LEN_ZERO       6'h00
`define LEN_ONE        6'h01

`endif

// *** inc/page_bus_pkg.sv ***
// Types shared by the page-mode external bus modules
package page_bus_pkg;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'h0,
    KIND_READ  = 2'h1,
    KIND_WRITE = 2'h2
  } kind_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDRHI = 3'h1,
    ST_SETUP  = 3'h2,
    ST_STROBE = 3'h3,
    ST_HOLD   = 3'h4
  } state_e;

  typedef struct packed {
    logic [5:0] alen;
    logic [5:0] setup;
    logic [5:0] strobe;
    logic [5:0] hold;
  } plan_s;

endpackage

// *** inc/phase_if.sv ***
// Handshake between the bus sequencer and its phase timer
`timescale 1ns/1ps
interface phase_if;
  logic       load;
  logic [5:0] len;
  logic       last;
  logic       last_nxt;

  modport timer (input load, input len, output last, output last_nxt);
  modport ctrl  (output load, output len, input last, input last_nxt);
endinterface

// *** hdl/phase_timer.sv ***
// Down counter timing one bus phase
`timescale 1ns/1ps
`include "page_bus_defines.svh"
module phase_timer
  import page_bus_pkg::*;
(
  input wire logic  clk,
  input wire logic  rst,
  phase_if.timer    ph
);
  logic [`LEN_W-1:0] cnt_r;

  // Load with length minus one so last marks the final clock
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= `LEN_ZERO;
    end else if (ph.load) begin
      cnt_r <= ph.len - `LEN_ONE;
    end else if (cnt_r != `LEN_ZERO) begin
      cnt_r <= cnt_r - `LEN_ONE;
    end
  end

  assign ph.last     = (cnt_r == `LEN_ZERO);
  assign ph.last_nxt = ph.load ? (ph.len == `LEN_ONE) : (cnt_r <= `LEN_ONE);
endmodule

// *** dv/ext_mem_model.sv ***
// External memory with upper address latch, far side of the bus
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic       program_store_strobe_n,
  input  wire logic       rd_n,
  input  wire logic [7:0] low_port_out,
  input  wire logic       low_port_oe,
  input  wire logic [7:0] high_port_out,
  output logic      [7:0] low_port_in,
  output logic      [7:0] high_port_in
);
  logic [7:0] hi_r;
  logic [7:0] last_r = 8'hC3;
  logic [7:0] dat;
  logic       rdg;
  // Latch keeps the upper byte; last byte kept for released ports
  always @(posedge clk) begin
    if (ale) begin
      hi_r <= high_port_out;
    end
    if (rdg) begin
      last_r <= dat;
    end
  end
  // Answer on the floated port; released ports show inverted last byte, never a stale copy
  always @* begin
    rdg = !program_store_strobe_n || !rd_n;
    dat = hi_r ^ (low_port_oe ? low_port_out : high_port_out) ^ 8'h5A;
    low_port_in = ~last_r;
    high_port_in = ~last_r;
    if (rdg && low_port_oe) begin
      high_port_in = dat;
    end else if (rdg) begin
      low_port_in = dat;
    end
  end
endmodule

// *** dv/page_mode_external_bus_chk.sv ***
// Concurrent checks on the page-mode bus pins
`timescale 1ns/1ps
module page_mode_external_bus_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [15:0] req_addr,
  input wire logic [7:0]  req_wdata,
  input wire logic [2:0]  stretch_select,
  input wire logic        address_control_reg_write,
  input wire logic        timed_access_open,
  input wire logic [7:0]  address_control_reg,
  input wire logic [7:0]  low_port_out,
  input wire logic        low_port_oe,
  input wire logic [7:0]  high_port_out,
  input wire logic        high_port_oe,
  input wire logic        ale,
  input wire logic        program_store_strobe_n,
  input wire logic        rd_n,
  input wire logic        wr_n
);
  logic [15:0] a_q, a_d;
  logic [7:0]  w_q, w_d;
  logic [2:0]  c_q, c_d, c_s;
  logic [5:0]  n_r;
  logic        pm1, sel0, low_n, ps_n;
  assign pm1   = address_control_reg[7] && address_control_reg[6:5] != 2'h3;
  assign sel0  = address_control_reg[7] && address_control_reg[6:5] == 2'h0;
  assign low_n = !rd_n || !wr_n;
  assign ps_n  = program_store_strobe_n;
  // Request captured at take, delayed one clock since pins lag the sequencer
  always_ff @(posedge clk) begin
    if (req_valid && req_ready) begin
      a_q <= req_addr;
      w_q <= req_wdata;
      c_q <= stretch_select;
    end
    a_d <= a_q;
    w_d <= w_q;
    c_d <= c_q;
  end
  // Strobe width; code frozen at first low clock as the next take may move c_d
  always_ff @(posedge clk) begin
    n_r <= (low_n && !rst) ? n_r + 6'h01 : 6'h00;
    if (low_n && n_r == 6'h00) begin
      c_s <= c_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ale_idle; pm1 && ale |-> rd_n && wr_n && ps_n && !low_port_oe; endproperty
  a_ale_idle: assert property (p_ale_idle) else $error("strobe or low port active in latch phase");
  property p_ale_hi; pm1 && ale |-> high_port_oe && high_port_out == a_d[15:8]; endproperty
  a_ale_hi: assert property (p_ale_hi) else $error("upper byte wrong in latch phase");
  property p_hit_lo; pm1 && (!ps_n || low_n) |-> high_port_oe && high_port_out == a_d[7:0];
  endproperty
  a_hit_lo: assert property (p_hit_lo) else $error("low byte wrong on high port");
  property p_fetch_float; pm1 && !ps_n |-> !low_port_oe; endproperty
  a_fetch_float: assert property (p_fetch_float) else $error("low port driven in fetch");
  property p_rd_float; pm1 && !rd_n |-> !low_port_oe; endproperty
  a_rd_float: assert property (p_rd_float) else $error("low port driven in read");
  property p_wr_drive; pm1 && !wr_n |-> low_port_oe && low_port_out == w_d; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data wrong on low port");
  property p_pm2_lo;
    address_control_reg[7:5] == 3'h7 && !ps_n |-> low_port_oe && low_port_out == a_d[7:0];
  endproperty
  a_pm2_lo: assert property (p_pm2_lo) else $error("low address wrong in fetch");
  property p_sel1_ps; address_control_reg[7:5] == 3'h5 && $fell(ps_n) |=> ps_n; endproperty
  a_sel1_ps: assert property (p_sel1_ps) else $error("fetch strobe not one clock");
  property p_width;
    sel0 && !low_n && n_r != 6'h00 |-> n_r == (c_s == 3'h0 ? 6'h01 : {1'b0, c_s, 2'h0} - 6'h01);
  endproperty
  a_width: assert property (p_width) else $error("data strobe width wrong");
  property p_lock; address_control_reg_write && !timed_access_open |=> $stable(address_control_reg); endproperty
  a_lock: assert property (p_lock) else $error("untimed control write took effect");
  c_b2b: cover property (sel0 && !ps_n [*3]);
  c_miss: cover property (pm1 && ale);
  c_wide: cover property (sel0 && n_r == 6'h1B);
endmodule

bind page_mode_external_bus page_mode_external_bus_chk i_chk (
  .clk (clk), .rst (rst), .req_valid (req_valid), .req_ready (req_ready),
  .req_addr (req_addr), .req_wdata (req_wdata), .stretch_select (stretch_select),
  .address_control_reg_write (address_control_reg_write), .timed_access_open (timed_access_open),
  .address_control_reg (address_control_reg), .low_port_out (low_port_out),
  .low_port_oe (low_port_oe), .high_port_out (high_port_out), .high_port_oe (high_port_oe),
  .ale (ale), .program_store_strobe_n (program_store_strobe_n), .rd_n (rd_n), .wr_n (wr_n)
);

// *** dv/page_mode_external_bus_tb_top.sv ***
// Self-checking bench for the page-mode external bus
`timescale 1ns/1ps
module page_mode_external_bus_tb_top;
  import page_bus_pkg::*;
  typedef struct packed {logic chk; logic [7:0] dat; int due;} note_s;
  logic        clk = 1'b0, rst = 1'b1, req_valid = 1'b0, address_control_reg_write = 1'b0;
  logic        timed_access_open = 1'b0, req_ready, resp_valid, page_miss_seen;
  logic [1:0]  req_kind = 2'h0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0]  req_wdata = 8'h00, address_control_reg_wdata = 8'h00, resp_rdata, address_control_reg;
  logic [2:0]  stretch_select = 3'h0;
  logic [7:0]  low_port_in, low_port_out, high_port_in, high_port_out;
  logic        low_port_oe, high_port_oe, ale, program_store_strobe_n, rd_n, wr_n;
  logic [7:0]  pg_last;
  logic        pg_ok = 1'b0, prev_data = 1'b0;
  logic [7:0]  mode = 8'h00;
  note_s       q[$];
  note_s       m;
  int          n_fail = 0, tests_run = 0, cyc = 0, seed = 32'h03E8, s, c, r;

  page_mode_external_bus i_dut (
    .clk (clk), .rst (rst), .req_valid (req_valid), .req_kind (req_kind),
    .req_addr (req_addr), .req_wdata (req_wdata), .req_ready (req_ready),
    .resp_valid (resp_valid), .resp_rdata (resp_rdata), .address_control_reg_write (address_control_reg_write),
    .address_control_reg_wdata (address_control_reg_wdata), .timed_access_open (timed_access_open),
    .stretch_select (stretch_select), .address_control_reg (address_control_reg),
    .page_miss_seen (page_miss_seen), .low_port_in (low_port_in),
    .low_port_out (low_port_out), .low_port_oe (low_port_oe), .high_port_in (high_port_in),
    .high_port_out (high_port_out), .high_port_oe (high_port_oe), .ale (ale),
    .program_store_strobe_n (program_store_strobe_n), .rd_n (rd_n), .wr_n (wr_n)
  );
  ext_mem_model i_mem (
    .clk (clk), .ale (ale), .program_store_strobe_n (program_store_strobe_n), .rd_n (rd_n),
    .low_port_out (low_port_out), .low_port_oe (low_port_oe), .high_port_out (high_port_out),
    .low_port_in (low_port_in), .high_port_in (high_port_in)
  );

  // Clock and cycle count for due times
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Control write, entered just after an edge
  task automatic set_address_control_reg(input logic [7:0] v, input logic open);
    address_control_reg_wdata = v;
    timed_access_open = open;
    address_control_reg_write = 1'b1;
    @(posedge clk);
    #1 address_control_reg_write = 1'b0;
    timed_access_open = 1'b0;
    @(posedge clk);
    #1 pg_ok = pg_ok && !open;
    if (open) mode = v;
  endtask

  // One access: predict length and data, hold request until taken
  task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic [2:0] cd);
    int t, sc, h, i;
    logic miss, en, dm;
    logic [1:0] sel;
    en = mode[7];
    sel = mode[6:5];
    dm = (k != 2'h0);
    miss = !pg_ok || a[15:8] != pg_last || (sel == 2'h0 && (dm || prev_data));
    sc = (cd < 3'h4) ? cd : cd + 3;
    h = (sel == 2'h0) ? 1 : (sel == 2'h1) ? 2 : 4;
    if (!en || (sel == 2'h3 && dm)) t = 4 + (dm ? 4 * sc : 0);
    else if (sel == 2'h3) t = miss ? 4 : 2;
    else t = (miss ? 2 * h : h) + (dm ? 4 * sc : 0);
    pg_ok = en;
    pg_last = a[15:8];
    prev_data = dm;
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_wdata = 8'($random(seed));
    stretch_select = cd;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 300) begin
      n_fail++;
      summarize();
    end
    @(posedge clk);
    #1 q.push_back('{k != 2'h2 && en, a[15:8] ^ a[7:0] ^ 8'h5A, cyc + t + 1});
    if (en) check("page miss", page_miss_seen, miss || (sel == 2'h3 && dm));
  endtask

  task automatic drain;
    int i;
    req_valid = 1'b0;
    for (i = 0; i < 3000 && q.size() != 0; i++) @(posedge clk);
    if (q.size() != 0) begin
      n_fail++;
      summarize();
    end
    @(posedge clk);
    #1;
  endtask

  // Result watcher: oldest note against each finished transfer
  always @(negedge clk) begin
    if (!rst && resp_valid === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected response", 1, 0);
      end else begin
        m = q.pop_front();
        check("response cycle", cyc, m.due);
        if (m.chk) check("read data", resp_rdata, m.dat);
      end
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    check("control reset", address_control_reg, 8'h00);
    acc(2'h0, 16'h1234, 3'h0);
    drain();
    set_address_control_reg(8'hE0, 1'b0);
    check("untimed write", address_control_reg, 8'h00);
    for (s = 0; s < 4; s++) begin
      set_address_control_reg({1'b1, 2'(s), 5'h00}, 1'b1);
      check("timed write", address_control_reg, {1'b1, 2'(s), 5'h00});
      acc(2'h0, 16'h3410, 3'h0);
      acc(2'h0, 16'h3411, 3'h0);
      acc(2'h0, 16'h3412, 3'h0);
      acc(2'h0, 16'h3500, 3'h0);
      acc(2'h1, 16'h3501, 3'h0);
      acc(2'h0, 16'h3502, 3'h0);
      acc(2'h2, 16'h3503, 3'h0);
      for (c = 0; c < 8; c++) acc(c[0] ? 2'h2 : 2'h1, 16'(32'h3580 + c), 3'(c));
      for (c = 0; c < 16; c++) begin
        r = $random(seed);
        acc(2'((r & 32'hFFFF) % 3), {7'h1A, r[24:16]}, r[30:28]);
      end
      drain();
    end
    summarize();
  end
endmodule
